/* File: sipmc_host.sv */
// sipmc_host: AHB-Lite master standing in for the host processor.
// assumes one slave whose hreadyout is returned as hready_i.
module sipmc_host
    import sipmc_pkg::*;
#(
    parameter int GAP_CYC = 20
)
(
    input wire logic clk_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    input wire sipmc_pstate_t pstate_i,
    output logic hsel_o,
    output logic [31:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================================
    // bus state
    int hang_cnt = 0;
    int cyc = 0;
    int last_wr = 0;
    bit pace = 1'b1;
    initial
    begin
        hsel_o = 1'b0;
        haddr_o = 32'h0;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o = HSIZE_WORD;
        hwdata_o = 32'h0;
    end
    always @(posedge clk_i) cyc <= cyc + 1;
    // ==========================================================
    // single word transfer
    task automatic wait_rdy();
        int n;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (hready_i !== 1'b1 && n < 50);
        if (n >= 50) hang_cnt++;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r);
        // one edge first, so the state seen includes the last write
        @(posedge clk_i);
        // low-power writes spaced out unless a scenario breaks it
        if (w && pace && pstate_i == PS_LOWPOWER)
            while (cyc - last_wr < GAP_CYC) @(posedge clk_i);
        hsel_o <= 1'b1;
        haddr_o <= {24'h0, a};
        htrans_o <= 2'h2;
        hwrite_o <= w;
        wait_rdy();
        htrans_o <= 2'h0;
        hsel_o <= 1'b0;
        hwdata_o <= d;
        wait_rdy();
        r = hrdata_i;
        hwdata_o <= ~d;
        if (w) last_wr = cyc;
    endtask
endmodule

/* File: sipmc_pkg.sv */
// sipmc_pkg: register map, field layout, timing and types of the
// sensor init and power-mode controller.
// assumes one 25 MHz clock and an AHB-Lite master with 32-bit data.
package sipmc_pkg;
    // ==========================================================
    // register map, byte addresses
    localparam logic [7:0] A_PWR_CFG = 8'h00;
    localparam logic [7:0] A_SNS_EN = 8'h04;
    localparam logic [7:0] A_ACC_SET = 8'h08;
    localparam logic [7:0] A_INIT_CTL = 8'h0c;
    localparam logic [7:0] A_FEAT_IN = 8'h10;
    localparam logic [7:0] A_STATUS = 8'h14;
    localparam logic [7:0] A_TIME = 8'h18;
    localparam logic [7:0] A_PSTATE = 8'h1c;
    localparam logic [7:0] A_FIFO_DAT = 8'h20;
    localparam logic [7:0] A_FIFO_LVL = 8'h24;
    localparam logic [7:0] A_CMD = 8'h28;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // ==========================================================
    // field positions
    localparam int B_APS = 0;
    localparam int B_SELFWAKE = 1;
    localparam int B_AUX_EN = 0;
    localparam int B_ACC_EN = 2;
    localparam int B_PERF = 7;
    localparam int B_MSG = 0;
    localparam int B_GAP_ERR = 1;
    // ==========================================================
    // reset values and command codes
    localparam logic R_APS = 1'b1;
    localparam logic R_SELFWAKE = 1'b0;
    localparam logic R_PERF = 1'b1;
    localparam logic R_SNS_EN = 1'b0;
    localparam logic [7:0] R_INIT_CTL = 8'h00;
    localparam logic [7:0] INIT_LOAD = 8'h00;
    localparam logic [7:0] INIT_START = 8'h01;
    localparam logic [7:0] SOFT_RESET_CMD = 8'h5a;
    // ==========================================================
    // timing
    localparam int CLK_NS = 40;
    localparam int SENSOR_TICK_NS = 39250;
    localparam int SENSOR_TICK_CYC = SENSOR_TICK_NS / CLK_NS;
    localparam int INIT_DONE_MS = 140;
    localparam int LP_GAP_US = 450;
    localparam int TIME_W = 24;
    localparam int FEAT_W = 16;
    // ==========================================================
    // types
    typedef enum logic [1:0] {
        PS_CONFIG = 2'h0,
        PS_SUSPEND = 2'h1,
        PS_LOWPOWER = 2'h3,
        PS_PERF = 2'h2
    } sipmc_pstate_t;
    typedef enum logic [1:0] {
        IN_LOAD = 2'h0,
        IN_RUN = 2'h1,
        IN_DONE = 2'h3
    } sipmc_init_t;
    typedef struct packed {
        logic mapped;
        logic write;
        logic [7:0] addr;
    } sipmc_req_t;
    typedef struct packed {
        logic self_wakeup;
        logic adv_power_save;
    } sipmc_pwr_t;
endpackage

/* File: sipmc_top.sv */
// sipmc_top: init sequencer, power-mode decode, sensor time and
// sample fifo of the acceleration sensor, behind an AHB-Lite slave.
// assumes the only slave on the bus: hready_i is its own hreadyout.
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
module sipmc_top
    import sipmc_pkg::*;
#(
    parameter int unsigned INIT_DONE_CYC = INIT_DONE_MS * 1000000 / CLK_NS,
    parameter int unsigned LP_GAP_CYC = (LP_GAP_US * 1000 + CLK_NS - 1) / CLK_NS,
    parameter int unsigned SAMPLE_DIV_CYC = 1000,
    parameter int unsigned FEAT_DEPTH = 64,
    parameter int unsigned FIFO_DEPTH = 16,
    parameter int unsigned FIFO_WM = 4
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output sipmc_pstate_t power_state_o,
    output logic init_done_o
);
    localparam int FP_W = $clog2(FEAT_DEPTH);
    localparam int FF_W = $clog2(FIFO_DEPTH);

    sipmc_req_t req_q;
    logic ph_q, hready_q, hresp_q, soft_rst_q, sys_rst;
    logic accept, wr_en, rd_en;
    logic [31:0] hrdata_q, rdata_d;
    sipmc_pwr_t pwr_q;
    logic acc_en_q, aux_en_q, perf_q, lp_cond;
    logic [7:0] init_ctl_q;
    sipmc_init_t init_st_q;
    logic [31:0] init_cnt_q, gap_cnt_q, tick_cnt_q, smp_cnt_q;
    logic msg_q, gap_err_q, smp_tick;
    logic [TIME_W-1:0] time_q;
    logic [FEAT_W-1:0] feat_mem [FEAT_DEPTH];
    logic [FP_W-1:0] feat_ptr_q;
    logic feat_wr, feat_rd;
    sipmc_pstate_t pstate_q;
    logic [FEAT_W-1:0] fifo_mem [FIFO_DEPTH];
    logic [FF_W-1:0] wptr_q, rptr_q;
    logic [FF_W:0] fcnt_q;
    logic push, pop, fifo_rd, fifo_rd_ok, wake_q;

    function automatic logic hit(input sipmc_req_t r, input logic [7:0] a);
        return r.mapped && (r.addr == a);
    endfunction

    function automatic sipmc_pstate_t decode_pstate(input logic aps,
        input logic acc, input logic perf);
        if (acc && perf)
            return PS_PERF;
        else if (!aps)
            return PS_CONFIG;
        else if (!acc)
            return PS_SUSPEND;
        else
            return PS_LOWPOWER;
    endfunction

    // ==========================================================
    // bus slave: one wait state so read data leaves a flop
    assign accept = hsel_i & htrans_i[1] & hready_i;
    assign wr_en = ph_q & req_q.write;
    assign rd_en = ph_q & ~req_q.write;
    assign sys_rst = reset_i | soft_rst_q;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            ph_q <= 1'b0;
            hready_q <= 1'b1;
            hresp_q <= 1'b0;
            req_q <= '0;
        end
        else
        begin
            ph_q <= accept;
            hready_q <= ~accept;
            if (accept)
            begin
                // one register per transfer, words only
                req_q.mapped <= (haddr_i[31:8] == 24'h0)
                    && (hsize_i == HSIZE_WORD);
                req_q.write <= hwrite_i;
                req_q.addr <= haddr_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            hrdata_q <= 32'h0;
        else if (rd_en)
            hrdata_q <= rdata_d;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            soft_rst_q <= 1'b0;
        else
            soft_rst_q <= wr_en && hit(req_q, A_CMD)
                && (hwdata_i[7:0] == SOFT_RESET_CMD);
    end

    // ==========================================================
    // power configuration and sensor enables, kept across modes
    always_ff @(posedge clk_i)
    begin
        if (sys_rst)
        begin
            pwr_q.adv_power_save <= R_APS;
            pwr_q.self_wakeup <= R_SELFWAKE;
        end
        else if (msg_q == 1'b0 && init_st_q == IN_RUN
            && init_cnt_q == INIT_DONE_CYC - 1)
            pwr_q.adv_power_save <= 1'b0;
        else if (wr_en && hit(req_q, A_PWR_CFG))
        begin
            pwr_q.adv_power_save <= hwdata_i[B_APS];
            pwr_q.self_wakeup <= hwdata_i[B_SELFWAKE];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst)
        begin
            acc_en_q <= R_SNS_EN;
            aux_en_q <= R_SNS_EN;
        end
        else if (wr_en && hit(req_q, A_SNS_EN))
        begin
            // enables live apart from the mode selection
            acc_en_q <= hwdata_i[B_ACC_EN];
            aux_en_q <= hwdata_i[B_AUX_EN];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst)
            perf_q <= R_PERF;
        else if (wr_en && hit(req_q, A_ACC_SET))
            perf_q <= hwdata_i[B_PERF];
    end

    // mode changes touch no register and no fifo entry
    always_ff @(posedge clk_i)
    begin
        if (sys_rst)
            pstate_q <= PS_SUSPEND;
        else
            pstate_q <= decode_pstate(pwr_q.adv_power_save, acc_en_q,
                perf_q);
    end
    assign lp_cond = pwr_q.adv_power_save & ~perf_q & acc_en_q;

    // ==========================================================
    // init sequencer: load image, then one feature enable
    always_ff @(posedge clk_i)
    begin
        if (sys_rst)
            init_ctl_q <= R_INIT_CTL;
        else if (wr_en && hit(req_q, A_INIT_CTL))
            init_ctl_q <= hwdata_i[7:0];
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst)
        begin
            init_st_q <= IN_LOAD;
            init_cnt_q <= 32'h0;
            msg_q <= 1'b0;
        end
        else
        begin
            case (init_st_q)
                IN_LOAD:
                begin
                    if (wr_en && hit(req_q, A_INIT_CTL)
                        && hwdata_i[7:0] == INIT_START)
                        init_st_q <= IN_RUN;
                end
                IN_RUN:
                begin
                    // result posted a fixed time after enable
                    if (init_cnt_q == INIT_DONE_CYC - 1)
                    begin
                        init_st_q <= IN_DONE;
                        msg_q <= 1'b1;
                    end
                    else
                        init_cnt_q <= init_cnt_q + 32'h1;
                end
                IN_DONE:
                    init_st_q <= IN_DONE; // later enables ignored
                default:
                    init_st_q <= IN_LOAD;
            endcase
        end
    end

    // image upload and read-back, 16 bits (an even byte count) per
    // transfer; the pointer rewinds on every init control write
    assign feat_wr = wr_en && hit(req_q, A_FEAT_IN)
        && init_st_q == IN_LOAD && init_ctl_q == INIT_LOAD;
    assign feat_rd = rd_en && hit(req_q, A_FEAT_IN);

    always_ff @(posedge clk_i)
    begin
        if (sys_rst)
            feat_ptr_q <= '0;
        else if (wr_en && hit(req_q, A_INIT_CTL))
            feat_ptr_q <= '0;
        else if (feat_wr || feat_rd)
            feat_ptr_q <= feat_ptr_q + 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (feat_wr)
            feat_mem[feat_ptr_q] <= hwdata_i[FEAT_W-1:0];
    end

    // ==========================================================
    // sensor time and low-power write spacing monitor
    always_ff @(posedge clk_i)
    begin
        if (sys_rst)
        begin
            tick_cnt_q <= 32'h0;
            time_q <= '0;
        end
        else if (tick_cnt_q == 32'(SENSOR_TICK_CYC - 1))
        begin
            tick_cnt_q <= 32'h0;
            time_q <= time_q + 1'b1;
        end
        else
            tick_cnt_q <= tick_cnt_q + 32'h1;
    end

    // the host owns the spacing; the block only flags a short gap
    always_ff @(posedge clk_i)
    begin
        if (sys_rst)
        begin
            gap_cnt_q <= LP_GAP_CYC;
            gap_err_q <= 1'b0;
        end
        else
        begin
            if (wr_en)
                gap_cnt_q <= 32'h0;
            else if (gap_cnt_q < LP_GAP_CYC)
                gap_cnt_q <= gap_cnt_q + 32'h1;
            // set wins over a clear in the same cycle
            if (wr_en && pstate_q == PS_LOWPOWER
                && gap_cnt_q < LP_GAP_CYC)
                gap_err_q <= 1'b1;
            else if (wr_en && hit(req_q, A_STATUS) && hwdata_i[B_GAP_ERR])
                gap_err_q <= 1'b0;
        end
    end

    // ==========================================================
    // sample fifo: logs in performance and low power
    assign smp_tick = (smp_cnt_q == SAMPLE_DIV_CYC - 1);
    assign push = smp_tick && (pstate_q == PS_PERF
        || pstate_q == PS_LOWPOWER)
        && fcnt_q != (FF_W + 1)'(FIFO_DEPTH);
    assign fifo_rd = rd_en && hit(req_q, A_FIFO_DAT);
    // in low power only a self-wakeup watermark opens the fifo
    assign fifo_rd_ok = (pstate_q != PS_LOWPOWER) || wake_q;
    assign pop = fifo_rd && fifo_rd_ok && fcnt_q != '0;

    always_ff @(posedge clk_i)
    begin
        if (sys_rst || smp_tick)
            smp_cnt_q <= 32'h0;
        else
            smp_cnt_q <= smp_cnt_q + 32'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst)
        begin
            wptr_q <= '0;
            rptr_q <= '0;
            fcnt_q <= '0;
        end
        else
        begin
            if (push)
                wptr_q <= wptr_q + 1'b1;
            if (pop)
                rptr_q <= rptr_q + 1'b1;
            if (push && !pop)
                fcnt_q <= fcnt_q + 1'b1;
            else if (pop && !push)
                fcnt_q <= fcnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (push)
            fifo_mem[wptr_q] <= time_q[FEAT_W-1:0];
    end

    // window stays open until the read-out drains the fifo
    always_ff @(posedge clk_i)
    begin
        if (sys_rst)
            wake_q <= 1'b0;
        else if (pstate_q == PS_LOWPOWER && pwr_q.self_wakeup
            && fcnt_q >= (FF_W + 1)'(FIFO_WM))
            wake_q <= 1'b1;
        else if (pop && fcnt_q == (FF_W + 1)'(1) && !push)
            wake_q <= 1'b0;
    end

    // ==========================================================
    // read data; unmapped addresses read zero
    always_comb
    begin
        rdata_d = 32'h0;
        if (hit(req_q, A_PWR_CFG))
        begin
            rdata_d[B_APS] = pwr_q.adv_power_save;
            rdata_d[B_SELFWAKE] = pwr_q.self_wakeup;
        end
        else if (hit(req_q, A_SNS_EN))
        begin
            rdata_d[B_ACC_EN] = acc_en_q;
            rdata_d[B_AUX_EN] = aux_en_q;
        end
        else if (hit(req_q, A_ACC_SET))
            rdata_d[B_PERF] = perf_q;
        else if (hit(req_q, A_INIT_CTL))
            rdata_d[7:0] = init_ctl_q;
        else if (hit(req_q, A_FEAT_IN))
            rdata_d[FEAT_W-1:0] = feat_mem[feat_ptr_q];
        else if (hit(req_q, A_STATUS))
        begin
            rdata_d[B_MSG] = msg_q;
            rdata_d[B_GAP_ERR] = gap_err_q;
        end
        else if (hit(req_q, A_TIME))
            rdata_d[TIME_W-1:0] = time_q;
        else if (hit(req_q, A_PSTATE))
            rdata_d[1:0] = pstate_q;
        else if (hit(req_q, A_FIFO_DAT) && pop)
            rdata_d[FEAT_W-1:0] = fifo_mem[rptr_q];
        else if (hit(req_q, A_FIFO_LVL))
            rdata_d[FF_W:0] = fcnt_q;
    end

    assign hrdata_o = hrdata_q;
    assign hreadyout_o = hready_q;
    assign hresp_o = hresp_q;
    assign power_state_o = pstate_q;
    assign init_done_o = msg_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    chk_soft_reset_suspend: assert property (
        soft_rst_q |=> !acc_en_q && pwr_q.adv_power_save ##1
            pstate_q == PS_SUSPEND)
        else $error("soft reset did not return to suspend");
    chk_time_step: assert property (
        !sys_rst && !$past(sys_rst) && $changed(time_q) |->
            $past(tick_cnt_q) == 32'(SENSOR_TICK_CYC - 1))
        else $error("sensor time stepped off its period");
    chk_init_bound: assert property (
        init_st_q == IN_RUN |-> init_cnt_q < INIT_DONE_CYC && !msg_q)
        else $error("init result late or early");
    chk_enable_once: assert property (
        init_st_q == IN_DONE && !soft_rst_q |=> init_st_q == IN_DONE)
        else $error("init sequencer left done state");
    chk_config_after: assert property (
        $rose(msg_q) |-> !pwr_q.adv_power_save ##1
            pstate_q != PS_LOWPOWER)
        else $error("init done outside configuration mode");
    chk_lowpower_cond: assert property (
        !sys_rst && pstate_q == PS_LOWPOWER |-> $past(lp_cond))
        else $error("low power entered without its conditions");
    chk_fifo_logs: assert property (
        !sys_rst && push && !pop |=> fcnt_q == $past(fcnt_q) + 1'b1)
        else $error("sample not logged into fifo");
    chk_fifo_gate: assert property (
        fifo_rd && !fifo_rd_ok |=> hrdata_q == 32'h0 && $stable(rptr_q))
        else $error("fifo read while closed");
    chk_feat_ptr: assert property (
        feat_wr && !sys_rst |=> feat_ptr_q == $past(feat_ptr_q) + 1'b1)
        else $error("image pointer did not advance");
    chk_bus_wait: assert property (
        accept |=> !hreadyout_o ##1 hreadyout_o)
        else $error("bus answer not one wait state");
endmodule

/* File: testbench.sv */
// testbench: init sequence, power-mode decode, sensor time, fifo
// access and soft reset of sipmc_top, driven through sipmc_host.
// assumes scaled counts: init 50, gap 20, sample every 10 cycles.
module testbench
    import sipmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int GAP = 20;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic hsel, hwrite, hready, hresp, done;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    sipmc_pstate_t pstate;
    int error_cnt = 0;
    int check_count = 0;
    logic [31:0] seed = 32'h33c35198;
    logic [15:0] img [8];
    initial forever #20 clk_i = ~clk_i;
    sipmc_top #(.INIT_DONE_CYC(50), .LP_GAP_CYC(GAP),
        .SAMPLE_DIV_CYC(10)) uut (.clk_i(clk_i), .reset_i(reset_i),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .power_state_o(pstate), .init_done_o(done));
    sipmc_host #(.GAP_CYC(GAP)) host (.clk_i(clk_i), .hready_i(hready),
        .hrdata_i(hrdata), .pstate_i(pstate), .hsel_o(hsel),
        .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
        .hsize_o(hsize), .hwdata_o(hwdata));
    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic sipmc_pstate_t exp_ps(logic aps, logic acc,
                                             logic perf);
        if (acc && perf) return PS_PERF;
        if (!aps) return PS_CONFIG;
        if (!acc) return PS_SUSPEND;
        return PS_LOWPOWER;
    endfunction
    task automatic tally_and_finish();
        if (error_cnt == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        host.xfer(w, a, d, r);
        if (host.hang_cnt != 0)
        begin
            error_cnt++;
            tally_and_finish();
        end
    endtask
    // full load sequence; host waits scaled to a few cycles
    task automatic init_seq();
        int n;
        repeat (25) @(posedge clk_i);
        acc(1, A_PWR_CFG, 32'h0);
        repeat (12) @(posedge clk_i);
        acc(1, A_INIT_CTL, {24'h0, INIT_LOAD});
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            img[i] = seed[15:0];
            acc(1, A_FEAT_IN, {16'h0, img[i]});
        end
        acc(1, A_INIT_CTL, {24'h0, INIT_LOAD});
        for (int i = 0; i < 8; i++)
        begin
            acc(0, A_FEAT_IN, 32'h0);
            chk("feat readback", {16'h0, img[i]}, r);
        end
        acc(1, A_INIT_CTL, {24'h0, INIT_START});
        n = 0;
        do
        begin
            acc(0, A_STATUS, 32'h0);
            n++;
        end
        while (r[B_MSG] !== 1'b1 && n < 20);
        chk("init result", 32'h1, {31'h0, r[B_MSG]});
        chk("init done pin", 32'h1, {31'h0, done});
        chk("state after init", PS_CONFIG, pstate);
    endtask
    // reset values, enables off, suspend
    task automatic chk_reset_vals();
        chk("reset state", PS_SUSPEND, pstate);
        chk("reset done", 32'h0, {31'h0, done});
        acc(0, A_PWR_CFG, 32'h0);
        chk("pwr cfg reset", 32'h1, r);
        acc(0, A_SNS_EN, 32'h0);
        chk("enable reset", 32'h0, r);
        acc(0, A_ACC_SET, 32'h0);
        chk("accel reset", 32'h80, r);
    endtask
    // ==========================================================
    // main sequence
    logic [31:0] t0;
    initial
    begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        chk_reset_vals();
        acc(0, 8'h30, 32'h0);
        chk("unmapped read", 32'h0, r);
        init_seq();
        // every combination of the three decode bits
        for (int i = 0; i < 8; i++)
        begin
            acc(1, A_SNS_EN, {29'h0, i[1], 2'h1});
            acc(1, A_ACC_SET, {24'h0, i[2], 7'h0});
            acc(1, A_PWR_CFG, {31'h0, i[0]});
            repeat (3) @(posedge clk_i);
            chk("power state", exp_ps(i[0], i[1], i[2]), pstate);
            acc(0, A_SNS_EN, 32'h0);
            chk("enable kept", {29'h0, i[1], 2'h1}, r);
        end
        acc(0, A_STATUS, 32'h0);
        chk("no gap error", 32'h1, r);
        // sensor time: two reads exactly 3 ticks apart
        acc(0, A_TIME, 32'h0);
        t0 = r;
        repeat (3 * SENSOR_TICK_CYC - 4) @(posedge clk_i);
        acc(0, A_TIME, 32'h0);
        chk("time step", t0 + 32'h3, r);
        // flush samples logged while sensor time still read zero
        for (int i = 0; i < 16; i++)
            acc(0, A_FIFO_DAT, 32'h0);
        // performance mode fills the fifo
        acc(1, A_PWR_CFG, 32'h1);
        acc(1, A_SNS_EN, 32'h4);
        acc(1, A_ACC_SET, 32'h80);
        repeat (200) @(posedge clk_i);
        acc(0, A_FIFO_LVL, 32'h0);
        chk("fifo full perf", 32'd16, r);
        acc(1, A_ACC_SET, 32'h0);
        repeat (3) @(posedge clk_i);
        chk("low power", PS_LOWPOWER, pstate);
        acc(0, A_FIFO_DAT, 32'h0);
        chk("fifo closed", 32'h0, r);
        acc(0, A_FIFO_LVL, 32'h0);
        chk("fifo kept", 32'd16, r);
        // no self-wakeup: host leaves power save and waits first
        acc(1, A_PWR_CFG, 32'h0);
        repeat (GAP) @(posedge clk_i);
        acc(0, A_FIFO_DAT, 32'h0);
        acc(0, A_FIFO_LVL, 32'h0);
        chk("fifo woken pop", 32'd15, r);
        acc(1, A_PWR_CFG, 32'h3);
        acc(0, A_FIFO_DAT, 32'h0);
        check_count++;
        if (r === 32'h0 || ^r === 1'bx)
        begin
            $display("[FAIL] fifo wake read expected nonzero seen %h", r);
            error_cnt++;
        end
        // two writes too close together in low power
        host.pace = 1'b0;
        acc(1, A_PWR_CFG, 32'h3);
        acc(1, A_PWR_CFG, 32'h3);
        host.pace = 1'b1;
        acc(0, A_STATUS, 32'h0);
        chk("gap flag", 32'h3, r);
        acc(1, A_STATUS, 32'h2);
        acc(0, A_STATUS, 32'h0);
        chk("gap clear", 32'h1, r);
        // soft reset back to suspend, then a fresh init
        acc(1, A_CMD, {24'h0, SOFT_RESET_CMD});
        repeat (3) @(posedge clk_i);
        chk_reset_vals();
        init_seq();
        tally_and_finish();
    end
endmodule
